/* hw/convert_pkg.sv */
// shared constants and types for the decimal/binary convert and negate datapath
package convert_pkg;
  localparam int WORD_W = 16;
  localparam int DIGIT_W = 4;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [15:0] WORD_DEC_LIMIT = 16'h270f;
  localparam logic [31:0] DOUBLE_DEC_LIMIT = 32'h05f5e0ff;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int SIGN_BIT = 15;
  localparam int DIGITS_WORD = 4;
  localparam int DIGITS_DOUBLE = 8;

  typedef enum logic [2:0] {
    decimal_to_plain_word = 3'b000,
    decimal_to_plain_double = 3'b001,
    plain_to_decimal_word = 3'b010,
    plain_to_decimal_double = 3'b011,
    twos_complement_word = 3'b100,
    twos_complement_double = 3'b101
  } op_sel_t;
endpackage

/* hw/convert_if.sv */
// operand and result bundle between the datapath top and its converters
`timescale 1ns/100ps
interface convert_if;
  logic [31:0] dec_in_val;
  logic [31:0] bin_out_val;
  logic dec_bad;
  logic [31:0] bin_in_val;
  logic [31:0] dec_out_val;
  modport top (output dec_in_val, output bin_in_val, input bin_out_val, input dec_bad,
    input dec_out_val);
  modport to_plain (input dec_in_val, output bin_out_val, output dec_bad);
  modport to_decimal (input bin_in_val, output dec_out_val);
endinterface

/* hw/dec_to_plain.sv */
// combinational eight-digit packed decimal to binary converter
`timescale 1ns/100ps
module dec_to_plain #(
  parameter int DIGITS = 8
) (
  convert_if.to_plain cv
);
  import convert_pkg::*;
  always_comb begin
    logic [31:0] acc;
    logic bad;
    acc = 32'h0000_0000;
    bad = 1'b0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      // multiply by ten as shift-and-add to avoid a wide multiplier
      acc = (acc << 3) + (acc << 1) + {28'h0000000, cv.dec_in_val[i*DIGIT_W +: DIGIT_W]};
      if (cv.dec_in_val[i*DIGIT_W +: DIGIT_W] > DIGIT_MAX) begin
        bad = 1'b1;
      end
    end
    cv.bin_out_val = acc;
    cv.dec_bad = bad;
  end
endmodule // dec_to_plain

/* hw/plain_to_dec.sv */
// combinational 32-bit binary to eight-digit packed decimal converter (double dabble)
`timescale 1ns/100ps
module plain_to_dec #(
  parameter int DIGITS = 8
) (
  convert_if.to_decimal cv
);
  import convert_pkg::*;
  always_comb begin
    logic [63:0] sh;
    sh = {32'h0000_0000, cv.bin_in_val};
    for (int b = 0; b < 32; b++) begin
      for (int d = 0; d < DIGITS; d++) begin
        if (sh[32 + d*DIGIT_W +: DIGIT_W] > 4'h4) begin
          sh[32 + d*DIGIT_W +: DIGIT_W] = sh[32 + d*DIGIT_W +: DIGIT_W] + 4'h3;
        end
      end
      sh = sh << 1;
    end
    // out-of-range sources give truncated digits; the fault flag marks them
    cv.dec_out_val = sh[63:32];
  end
endmodule // plain_to_dec

/* hw/decimal_binary_convert_negate.sv */
// datapath for decimal/binary conversion and two's complement instructions
`timescale 1ns/100ps
module decimal_binary_convert_negate (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // request from sequencer
  input wire logic exec_in,
  input wire convert_pkg::op_sel_t op_sel_in,
  input wire logic [convert_pkg::WORD_W-1:0] src_lo_in,
  input wire logic [convert_pkg::WORD_W-1:0] src_hi_in,
  // results
  output logic [convert_pkg::WORD_W-1:0] res_lo_out,
  output logic [convert_pkg::WORD_W-1:0] res_hi_out,
  output logic fault_flag_out,
  output logic equals_flag_out,
  output logic negative_flag_out,
  output logic done_out
);
  import convert_pkg::*;

  convert_if cv ();

  logic [WORD_W-1:0] res_lo_ff;
  logic [WORD_W-1:0] res_hi_ff;
  logic fault_ff;
  logic equals_ff;
  logic negative_ff;
  logic done_ff;
  logic [WORD_W-1:0] nxt_res_lo;
  logic [WORD_W-1:0] nxt_res_hi;
  logic nxt_fault;
  logic nxt_negative;
  logic nxt_equals;
  logic [31:0] src_dbl;
  logic [31:0] neg_dbl;
  logic [WORD_W-1:0] neg_word;

  assign src_dbl = {src_hi_in, src_lo_in};
  // single-word forms feed zeroed upper digits so one converter serves both
  assign cv.dec_in_val = (op_sel_in == decimal_to_plain_double) ? src_dbl
                                                                : {16'h0000, src_lo_in};
  assign cv.bin_in_val = (op_sel_in == plain_to_decimal_double) ? src_dbl
                                                                : {16'h0000, src_lo_in};
  // wraps naturally, so the most negative value maps onto itself
  assign neg_word = ~src_lo_in + 16'h0001;
  assign neg_dbl = ~src_dbl + 32'h0000_0001;

  dec_to_plain #(.DIGITS(DIGITS_DOUBLE)) u_dec_to_plain (.cv(cv.to_plain));
  plain_to_dec #(.DIGITS(DIGITS_DOUBLE)) u_plain_to_dec (.cv(cv.to_decimal));

  always_comb begin
    nxt_res_lo = WORD_RESET;
    nxt_res_hi = WORD_RESET;
    nxt_fault = 1'b0;
    nxt_negative = 1'b0;
    unique case (op_sel_in)
      decimal_to_plain_word: begin
        nxt_res_lo = cv.bin_out_val[15:0];
        nxt_fault = cv.dec_bad;
        nxt_negative = 1'b0;
      end
      decimal_to_plain_double: begin
        nxt_res_lo = cv.bin_out_val[15:0];
        nxt_res_hi = cv.bin_out_val[31:16];
        nxt_fault = cv.dec_bad;
        nxt_negative = 1'b0;
      end
      plain_to_decimal_word: begin
        nxt_res_lo = cv.dec_out_val[15:0];
        nxt_fault = (src_lo_in > WORD_DEC_LIMIT);
      end
      plain_to_decimal_double: begin
        nxt_res_lo = cv.dec_out_val[15:0];
        nxt_res_hi = cv.dec_out_val[31:16];
        nxt_fault = (src_dbl > DOUBLE_DEC_LIMIT);
      end
      twos_complement_word: begin
        nxt_res_lo = neg_word;
        nxt_fault = 1'b0;
        nxt_negative = neg_word[SIGN_BIT];
      end
      twos_complement_double: begin
        nxt_res_lo = neg_dbl[15:0];
        nxt_res_hi = neg_dbl[31:16];
        nxt_fault = 1'b0;
        nxt_negative = neg_dbl[16 + SIGN_BIT];
      end
      default: begin
        // illegal select code: zero result, fault raised
        nxt_fault = 1'b1;
      end
    endcase
  end

  // equals follows the word actually written, even when fault marks it as junk
  assign nxt_equals = ({nxt_res_hi, nxt_res_lo} == 32'h0000_0000);

  // results and flags change only on an execute strobe
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_lo_ff <= WORD_RESET;
      res_hi_ff <= WORD_RESET;
    end else if (exec_in) begin
      res_lo_ff <= nxt_res_lo;
      res_hi_ff <= nxt_res_hi;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_ff <= 1'b0;
    end else if (exec_in) begin
      fault_ff <= nxt_fault;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      equals_ff <= 1'b0;
    end else if (exec_in) begin
      equals_ff <= nxt_equals;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      negative_ff <= 1'b0;
    end else if (exec_in) begin
      negative_ff <= nxt_negative;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= exec_in;
    end
  end

  assign res_lo_out = res_lo_ff;
  assign res_hi_out = res_hi_ff;
  assign fault_flag_out = fault_ff;
  assign equals_flag_out = equals_ff;
  assign negative_flag_out = negative_ff;
  assign done_out = done_ff;

  a_neg_word_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == twos_complement_word |=>
    res_lo_out == 16'h0000 - $past(src_lo_in) && res_hi_out == 16'h0000)
    else $error("single negation result wrong");

  a_neg_word_min: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == twos_complement_word && src_lo_in == 16'h8000 |=>
    res_lo_out == 16'h8000 && negative_flag_out)
    else $error("8000 negation not preserved");

  a_neg_dbl_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == twos_complement_double |=>
    {res_hi_out, res_lo_out} == 32'h0000_0000 - $past({src_hi_in, src_lo_in}))
    else $error("double negation result wrong");

  a_neg_dbl_min: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == twos_complement_double && src_dbl == 32'h8000_0000 |=>
    {res_hi_out, res_lo_out} == 32'h8000_0000)
    else $error("80000000 negation not preserved");

  a_neg_no_fault: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && (op_sel_in == twos_complement_word || op_sel_in == twos_complement_double)
    |=> !fault_flag_out)
    else $error("negation raised fault");

  a_neg_sign_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $past(exec_in) && $past(op_sel_in) == twos_complement_double |->
    negative_flag_out == res_hi_out[15])
    else $error("double negation sign flag wrong");

  // a strobe held through reset is not executed, so the edge after release is skipped
  a_equals_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $past(exec_in) && $past(rst_n_in) |->
    equals_flag_out == (res_hi_out == 16'h0000 && res_lo_out == 16'h0000))
    else $error("equals flag disagrees with result");

  a_dec_no_neg: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && (op_sel_in == decimal_to_plain_word || op_sel_in == decimal_to_plain_double)
    |=> !negative_flag_out)
    else $error("decimal conversion set negative");

  a_word_range: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == plain_to_decimal_word |=>
    fault_flag_out == ($past(src_lo_in) > 16'h270f))
    else $error("word range fault wrong");

  a_dbl_range: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == plain_to_decimal_double |=>
    fault_flag_out == ($past(src_dbl) > 32'h05f5e0ff))
    else $error("double range fault wrong");

  a_word_dec_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_word && src_lo_in == 16'h1234 |=>
    res_lo_out == 16'h04d2 && !fault_flag_out)
    else $error("decimal 1234 not converted");

  a_bad_digit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_word && src_lo_in[3:0] > 4'h9 |=>
    fault_flag_out)
    else $error("bad digit not faulted");

  a_hold_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !exec_in |=> $stable(res_lo_out) && $stable(fault_flag_out) && !done_out)
    else $error("outputs changed without strobe");

  a_flags_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !exec_in |=>
    $stable(res_hi_out) && $stable(equals_flag_out) && $stable(negative_flag_out))
    else $error("upper result or flags changed without strobe");

  a_done_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in |=> done_out)
    else $error("done pulse missing after strobe");

  // spot values below are ones the sequencer model issues, so each antecedent fires
  a_dec_word_hi: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_word |=>
    res_hi_out == 16'h0000)
    else $error("single decimal conversion left upper word set");

  a_dec_word_max: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_word && src_lo_in == 16'h9999 |=>
    res_lo_out == 16'h270f && !fault_flag_out)
    else $error("decimal 9999 not converted");

  a_dec_dbl_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_double && src_dbl == 32'h1234_5678 |=>
    {res_hi_out, res_lo_out} == 32'h00bc_614e && !fault_flag_out)
    else $error("decimal 12345678 not converted");

  a_dec_dbl_max: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_double && src_dbl == 32'h9999_9999 |=>
    {res_hi_out, res_lo_out} == 32'h05f5_e0ff && !fault_flag_out)
    else $error("decimal 99999999 not converted");

  a_dbl_bad_digit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_double && src_hi_in[15:12] > 4'h9 |=>
    fault_flag_out)
    else $error("bad upper digit not faulted");

  a_mid_bad_digit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_word && src_lo_in[7:4] > 4'h9 |=>
    fault_flag_out)
    else $error("bad tens digit not faulted");

  a_dec_zero_eq: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == decimal_to_plain_word && src_lo_in == 16'h0000 |=>
    equals_flag_out && !fault_flag_out)
    else $error("zero conversion did not raise equals");

  a_plain_word_val: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == plain_to_decimal_word && src_lo_in == 16'h04d2 |=>
    res_lo_out == 16'h1234 && res_hi_out == 16'h0000)
    else $error("binary 04d2 not converted");

  a_plain_word_top: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == plain_to_decimal_word && src_lo_in == 16'h270f |=>
    res_lo_out == 16'h9999 && !fault_flag_out)
    else $error("binary 270f not converted");

  a_plain_dbl_val: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == plain_to_decimal_double && src_dbl == 32'h00bc_614e |=>
    {res_hi_out, res_lo_out} == 32'h1234_5678)
    else $error("binary 00bc614e not converted");

  a_plain_dbl_carry: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == plain_to_decimal_double && src_dbl == 32'h0001_0000 |=>
    {res_hi_out, res_lo_out} == 32'h0006_5536)
    else $error("binary 00010000 not converted");

  a_plain_dbl_top: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == plain_to_decimal_double && src_dbl == 32'h05f5_e0ff |=>
    {res_hi_out, res_lo_out} == 32'h9999_9999 && !fault_flag_out)
    else $error("binary 05f5e0ff not converted");

  a_neg_word_sign: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == twos_complement_word |=>
    negative_flag_out == res_lo_out[15])
    else $error("single negation sign flag wrong");

  a_neg_zero_eq: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && op_sel_in == twos_complement_word && src_lo_in == 16'h0000 |=>
    equals_flag_out && !negative_flag_out)
    else $error("zero negation flags wrong");

  // unknown codes are not refused; they leave a zero result marked as a fault
  a_illegal_code: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    exec_in && (op_sel_in == op_sel_t'(3'b110) || op_sel_in == op_sel_t'(3'b111)) |=>
    fault_flag_out && equals_flag_out && !negative_flag_out &&
    res_lo_out == 16'h0000 && res_hi_out == 16'h0000)
    else $error("illegal select code not flagged");
endmodule // decimal_binary_convert_negate

/* bench/sequencer_model.sv */
// instruction sequencer model that issues operations to the datapath
`timescale 1ns/100ps
module sequencer_model (
  // clock
  input wire logic core_clk_in,
  // request to datapath
  output logic exec_out,
  output convert_pkg::op_sel_t op_sel_out,
  output logic [15:0] src_lo_out,
  output logic [15:0] src_hi_out
);
  import convert_pkg::*;
  initial begin
    exec_out = 1'b0;
    op_sel_out = twos_complement_word;
    src_lo_out = 16'h0000;
    src_hi_out = 16'h0000;
  end
  // one strobe cycle; operands flip afterwards so a stale sample cannot pass
  task automatic issue(input op_sel_t op, input logic [15:0] lo, input logic [15:0] hi);
    @(posedge core_clk_in);
    exec_out <= 1'b1;
    op_sel_out <= op;
    src_lo_out <= lo;
    src_hi_out <= hi;
    @(posedge core_clk_in);
    exec_out <= 1'b0;
    src_lo_out <= ~lo;
    src_hi_out <= ~hi;
  endtask
endmodule // sequencer_model

/* bench/decimal_binary_convert_negate_test.sv */
// self-checking bench for the convert and negate datapath
`timescale 1ns/100ps
module decimal_binary_convert_negate_test;
  import convert_pkg::*;
  logic core_clk_in;
  logic rst_n_in;
  logic exec_in;
  op_sel_t op_sel_in;
  logic [15:0] src_lo_in, src_hi_in, res_lo_out, res_hi_out;
  logic fault_flag_out, equals_flag_out, negative_flag_out, done_out;
  wire logic [35:0] all_out = {res_hi_out, res_lo_out, fault_flag_out, equals_flag_out,
    negative_flag_out, done_out};
  int errors;
  int total_checks;

  sequencer_model seq (.core_clk_in(core_clk_in), .exec_out(exec_in), .op_sel_out(op_sel_in),
    .src_lo_out(src_lo_in), .src_hi_out(src_hi_in));
  decimal_binary_convert_negate dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .exec_in(exec_in), .op_sel_in(op_sel_in), .src_lo_in(src_lo_in), .src_hi_in(src_hi_in),
    .res_lo_out(res_lo_out), .res_hi_out(res_hi_out), .fault_flag_out(fault_flag_out),
    .equals_flag_out(equals_flag_out), .negative_flag_out(negative_flag_out),
    .done_out(done_out));

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // result and equals are only defined when no fault is expected
  task automatic run(input op_sel_t op, input logic [31:0] src, input logic [31:0] exp,
      input logic ef, input logic en);
    seq.issue(op, src[15:0], src[31:16]);
    #1;
    check("done", done_out, 1'b1);
    check("fault", fault_flag_out, ef);
    if (!ef) begin
      check("result", {res_hi_out, res_lo_out}, exp);
      check("equals", equals_flag_out, exp == 32'h0);
    end
    if (op != plain_to_decimal_word && op != plain_to_decimal_double)
      check("negative", negative_flag_out, en);
  endtask

  task automatic t_reset;
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    #1;
    check("reset outputs", all_out, 36'h0);
    @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    check("released outputs", all_out, 36'h0);
  endtask

  task automatic t_dec_word;
    run(decimal_to_plain_word, 32'h0000_1234, 32'h0000_04d2, 1'b0, 1'b0);
    run(decimal_to_plain_word, 32'h0000_00a0, 32'h0, 1'b1, 1'b0);
    run(decimal_to_plain_word, 32'h0000_123b, 32'h0, 1'b1, 1'b0);
    run(decimal_to_plain_word, 32'h0000_9999, 32'h0000_270f, 1'b0, 1'b0);
    run(decimal_to_plain_word, 32'h0000_0000, 32'h0, 1'b0, 1'b0);
  endtask

  task automatic t_dec_double;
    run(decimal_to_plain_double, 32'h1234_5678, 32'h00bc_614e, 1'b0, 1'b0);
    run(decimal_to_plain_double, 32'h9999_9999, 32'h05f5_e0ff, 1'b0, 1'b0);
    run(decimal_to_plain_double, 32'ha000_0000, 32'h0, 1'b1, 1'b0);
    run(decimal_to_plain_double, 32'h0000_000f, 32'h0, 1'b1, 1'b0);
  endtask

  task automatic t_plain;
    run(plain_to_decimal_word, 32'h0000_04d2, 32'h0000_1234, 1'b0, 1'b0);
    run(plain_to_decimal_word, 32'h0000_270f, 32'h0000_9999, 1'b0, 1'b0);
    run(plain_to_decimal_word, 32'h0000_0000, 32'h0, 1'b0, 1'b0);
    run(plain_to_decimal_double, 32'h00bc_614e, 32'h1234_5678, 1'b0, 1'b0);
    run(plain_to_decimal_double, 32'h0001_0000, 32'h0006_5536, 1'b0, 1'b0);
    run(plain_to_decimal_double, 32'h05f5_e0ff, 32'h9999_9999, 1'b0, 1'b0);
    run(plain_to_decimal_double, 32'h05f5_e100, 32'h0, 1'b1, 1'b0);
    run(plain_to_decimal_word, 32'h0000_2710, 32'h0, 1'b1, 1'b0);
  endtask

  task automatic t_negate;
    run(twos_complement_word, 32'h5555_0001, 32'h0000_ffff, 1'b0, 1'b1);
    run(twos_complement_word, 32'h0000_8000, 32'h0000_8000, 1'b0, 1'b1);
    run(twos_complement_word, 32'h0000_0000, 32'h0, 1'b0, 1'b0);
    run(twos_complement_double, 32'h8000_0000, 32'h8000_0000, 1'b0, 1'b1);
    run(twos_complement_double, 32'hffff_0001, 32'h0000_ffff, 1'b0, 1'b0);
    run(twos_complement_double, 32'h0000_0001, 32'hffff_ffff, 1'b0, 1'b1);
  endtask

  task automatic t_hold;
    @(posedge core_clk_in);
    #1;
    check("done after", done_out, 1'b0);
    check("held result", {res_hi_out, res_lo_out}, 32'hffff_ffff);
  endtask

  // unknown select code: zero result, fault and equals up, negative down, done pulse
  task automatic t_illegal;
    seq.issue(op_sel_t'(3'b110), 16'h1234, 16'h5678);
    #1;
    check("illegal outputs", all_out, 36'h0_0000_000d);
  endtask

  // watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge core_clk_in);
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    total_checks = 0;
    rst_n_in = 1'b0;
    repeat (16) @(posedge core_clk_in);
    t_reset();
    t_dec_word();
    t_dec_double();
    t_plain();
    t_negate();
    t_hold();
    t_illegal();
    t_reset();
    report_and_stop();
  end
endmodule // decimal_binary_convert_negate_test
